// file: core/pic_host_pkg.sv
/*
  constants for the host-side controller of an eight-input priority
  interrupt controller: own apb register map, command codes, pin timing.
  assumes a 200 mhz clock.
*/
package pic_host_pkg;
  localparam int          CLK_MHZ          = 200;
  localparam int          STROBE_NS        = 100;
  localparam int          STROBE_CYC       = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W            = 8;
  // own apb registers
  localparam logic [11:0] OFF_CMD          = 12'h000;
  localparam logic [11:0] OFF_MASK         = 12'h004;
  localparam logic [11:0] OFF_STATUS       = 12'h008;
  localparam logic [11:0] OFF_VECTOR       = 12'h00c;
  // command field in OFF_CMD
  localparam int          CMD_LSB          = 8;
  localparam int          CMD_W            = 4;
  localparam int          LVL_LSB          = 0;
  localparam logic [3:0]  CMD_NOP          = 4'h0;
  localparam logic [3:0]  CMD_INIT         = 4'h1;
  localparam logic [3:0]  CMD_NS_EOS       = 4'h2;
  localparam logic [3:0]  CMD_SP_EOS       = 4'h3;
  localparam logic [3:0]  CMD_ROT_SP_EOS   = 4'h4;
  localparam logic [3:0]  CMD_SET_PRIO     = 4'h5;
  localparam logic [3:0]  CMD_SMM_SET      = 4'h6;
  localparam logic [3:0]  CMD_SMM_CLR      = 4'h7;
  localparam logic [3:0]  CMD_ACK          = 4'h8;
  // init options in OFF_CMD
  localparam int          LEVEL_BIT        = 4;
  localparam int          AUTO_BIT         = 5;
  // device-side opcodes on cmd_opcode pins
  localparam logic [2:0]  OP_INIT          = 3'h0;
  localparam logic [2:0]  OP_NS_EOS        = 3'h1;
  localparam logic [2:0]  OP_SP_EOS        = 3'h2;
  localparam logic [2:0]  OP_ROT_SP_EOS    = 3'h3;
  localparam logic [2:0]  OP_SET_PRIO      = 3'h4;
  localparam logic [2:0]  OP_SMM_SET       = 3'h5;
  localparam logic [2:0]  OP_SMM_CLR       = 3'h6;
  localparam logic [2:0]  OP_MASK_WR       = 3'h7;
  localparam int          ACK_PULSES       = 3;
  localparam logic [2:0]  DEFAULT_LEVEL    = 3'h7;
  localparam logic [7:0]  MASK_RESET       = 8'hff;
endpackage : pic_host_pkg

// file: core/pic_host.sv
/*
  host-side controller that drives an eight-input priority interrupt
  controller through a command strobe, mask write and acknowledge strobe.
  assumes the device samples commands on the rising edge of cmd_write and
  puts a level code on ack_level during the first acknowledge pulse.
*/
// Chosen here: the APB register port and the register offsets.
// Functional notes
// - host masks level before entering special masking; pic_host does not mask or check it on CMD_SMM_SET
// - leave special masking before nonspecific clear
// - after set-priority use specific clear
// - request held past first acknowledge fall
// - auto clear with level: keep interrupts off
module pic_host
  import pic_host_pkg::*;
#(
  parameter int STROBE_CYCLES = pic_host_pkg::STROBE_CYC
)(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // apb slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  // device pins
  input  wire logic       dev_int,
  input  wire logic [2:0] ack_level,
  output logic            cmd_write,
  output logic [2:0]      cmd_opcode,
  output logic [7:0]      cmd_data,
  output logic            acknowledge_strobe_n
);
  import pic_host_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_CMD   = 3'b001,
    S_GAP   = 3'b010,
    S_ACKLO = 3'b011,
    S_ACKHI = 3'b100
  } state_type;

  state_type        state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [1:0]       pulse_q;
  logic [7:0]       request_mask_q;
  logic             smm_q;
  logic             level_mode_q;
  logic             auto_eos_q;
  logic             set_prio_used_q;
  logic [2:0]       vector_q;
  logic             vector_valid_q;
  logic             busy;
  logic             wr_acc;
  logic [3:0]       cmd_code;
  logic [2:0]       lvl;
  logic             cmd_ok;
  logic             tick;

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  assign busy     = (state_q != S_IDLE);
  assign wr_acc   = psel && penable && pwrite && pready;
  assign cmd_code = pwdata[CMD_LSB +: CMD_W];
  assign lvl      = pwdata[LVL_LSB +: 3];
  assign pready   = !(psel && pwrite && busy &&
                      (paddr == OFF_CMD || paddr == OFF_MASK));
  // host refuses a nonspecific clear while special masking or set-priority is in use
  assign cmd_ok   = !(cmd_code == CMD_NS_EOS && (smm_q || set_prio_used_q));
  assign pslverr  = psel && penable && pready &&
                    ((paddr != OFF_CMD && paddr != OFF_MASK &&
                      paddr != OFF_STATUS && paddr != OFF_VECTOR) ||
                     (pwrite && paddr == OFF_CMD && !cmd_ok));
  assign tick     = (cnt_q == CNT_W'(STROBE_CYCLES - 1));

  always_comb
  begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      OFF_MASK:   prdata = {24'h00_0000, request_mask_q};
      OFF_STATUS: prdata = {26'h0, auto_eos_q, level_mode_q, set_prio_used_q,
                            smm_q, dev_int, busy};
      OFF_VECTOR: prdata = {28'h000_0000, vector_valid_q, vector_q};
      default:    prdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // command and acknowledge sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q              <= S_IDLE;
      cnt_q                <= '0;
      pulse_q              <= 2'h0;
      cmd_write            <= 1'b0;
      cmd_opcode           <= OP_INIT;
      cmd_data             <= 8'h00;
      acknowledge_strobe_n <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        S_IDLE:
        begin
          cnt_q <= '0;
          if (wr_acc && paddr == OFF_MASK)
          begin
            cmd_opcode <= OP_MASK_WR;
            cmd_data   <= pwdata[7:0];
            cmd_write  <= 1'b1;
            state_q    <= S_CMD;
          end
          else if (wr_acc && paddr == OFF_CMD && cmd_ok && cmd_code == CMD_ACK)
          begin
            // acknowledge only on demand, never on a priority change
            acknowledge_strobe_n <= 1'b0;
            pulse_q              <= 2'h0;
            state_q              <= S_ACKLO;
          end
          else if (wr_acc && paddr == OFF_CMD && cmd_ok &&
                   cmd_code != CMD_NOP && cmd_code < CMD_ACK)
          begin
            cmd_write <= 1'b1;
            state_q   <= S_CMD;
            cmd_data  <= {5'h00, lvl};
            unique case (cmd_code)
              CMD_INIT:
              begin
                cmd_opcode <= OP_INIT;
                cmd_data   <= {2'h0, pwdata[AUTO_BIT], pwdata[LEVEL_BIT], 4'h0};
              end
              CMD_NS_EOS:     cmd_opcode <= OP_NS_EOS;
              CMD_SP_EOS:     cmd_opcode <= OP_SP_EOS;
              CMD_ROT_SP_EOS: cmd_opcode <= OP_ROT_SP_EOS;
              CMD_SET_PRIO:   cmd_opcode <= OP_SET_PRIO;
              CMD_SMM_SET:    cmd_opcode <= OP_SMM_SET;
              CMD_SMM_CLR:    cmd_opcode <= OP_SMM_CLR;
              default:        cmd_opcode <= OP_INIT;
            endcase
          end
        end
        S_CMD, S_GAP:
        begin
          cnt_q <= tick ? '0 : cnt_q + 1'b1;
          if (tick)
          begin
            cmd_write <= 1'b0;
            state_q   <= (state_q == S_CMD) ? S_GAP : S_IDLE;
          end
        end
        S_ACKLO:
        begin
          cnt_q <= tick ? '0 : cnt_q + 1'b1;
          if (tick)
          begin
            acknowledge_strobe_n <= 1'b1;
            state_q              <= S_ACKHI;
          end
        end
        S_ACKHI:
        begin
          cnt_q <= tick ? '0 : cnt_q + 1'b1;
          if (tick)
          begin
            pulse_q <= pulse_q + 2'h1;
            if (pulse_q == 2'(ACK_PULSES - 1))
              state_q <= S_IDLE;
            else
            begin
              acknowledge_strobe_n <= 1'b0;
              state_q              <= S_ACKLO;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shadow of device mode state
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      request_mask_q  <= MASK_RESET;
      smm_q           <= 1'b0;
      level_mode_q    <= 1'b0;
      auto_eos_q      <= 1'b0;
      set_prio_used_q <= 1'b0;
    end
    else if (wr_acc && !busy && paddr == OFF_MASK)
      request_mask_q <= pwdata[7:0];
    else if (wr_acc && !busy && paddr == OFF_CMD && cmd_ok)
    begin
      unique case (cmd_code)
        CMD_INIT:
        begin
          level_mode_q    <= pwdata[LEVEL_BIT];
          auto_eos_q      <= pwdata[AUTO_BIT];
          smm_q           <= 1'b0;
          set_prio_used_q <= 1'b0;
        end
        CMD_SMM_SET:    smm_q <= 1'b1;
        CMD_SMM_CLR:    smm_q <= 1'b0;
        CMD_SET_PRIO:   set_prio_used_q <= 1'b1;
        CMD_SP_EOS,
        CMD_ROT_SP_EOS: set_prio_used_q <= 1'b0;
        default:        smm_q <= smm_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // vector capture at end of first acknowledge pulse
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      vector_q       <= DEFAULT_LEVEL;
      vector_valid_q <= 1'b0;
    end
    else if (wr_acc && !busy && paddr == OFF_CMD && cmd_code == CMD_ACK)
      vector_valid_q <= 1'b0;
    else if (state_q == S_ACKLO && tick && pulse_q == 2'h0)
    begin
      vector_q       <= ack_level;
      vector_valid_q <= 1'b1;
    end
  end

  a_ack_three: assert property (@(posedge clk) disable iff (rst)
    (state_q == S_ACKHI && tick && pulse_q == 2'h2) |=> state_q == S_IDLE)
    else $error("acknowledge did not end after third pulse");
  a_ns_refused: assert property (@(posedge clk) disable iff (rst)
    (psel && penable && pready && pwrite && paddr == OFF_CMD && cmd_code == CMD_NS_EOS &&
     smm_q)
      |-> pslverr)
    else $error("nonspecific clear accepted in special masking");
  a_prio_ns: assert property (@(posedge clk) disable iff (rst)
    (wr_acc && paddr == OFF_CMD && cmd_code == CMD_NS_EOS && set_prio_used_q)
      |=> !cmd_write)
    else $error("nonspecific clear sent after set priority");
  a_mask_sent: assert property (@(posedge clk) disable iff (rst)
    (wr_acc && !busy && paddr == OFF_MASK) |=> cmd_write && cmd_data == request_mask_q)
    else $error("mask write not forwarded");
  a_smm_hold: assert property (@(posedge clk) disable iff (rst)
    ($fell(smm_q)) |-> $past(wr_acc && (cmd_code == CMD_SMM_CLR || cmd_code == CMD_INIT)))
    else $error("special masking dropped without clear");
  a_ack_only: assert property (@(posedge clk) disable iff (rst)
    ($fell(acknowledge_strobe_n) && $past(state_q) == S_IDLE) |->
      $past(wr_acc && cmd_code == CMD_ACK))
    else $error("acknowledge started without request");
  a_init_mode: assert property (@(posedge clk) disable iff (rst)
    (wr_acc && !busy && paddr == OFF_CMD && cmd_code == CMD_INIT) |=>
      cmd_opcode == OP_INIT && cmd_data[LEVEL_BIT] == level_mode_q)
    else $error("trigger mode not sent at init");
  a_vec_first: assert property (@(posedge clk) disable iff (rst)
    (state_q == S_ACKLO && tick && pulse_q == 2'h0) |=> vector_valid_q)
    else $error("vector not captured at first pulse");
endmodule : pic_host

// file: tb/pic_dev_model.sv
/*
  behavioural model of the eight-input priority interrupt controller.
  assumes the opcodes, init bits and pulse count of pic_host_pkg.
*/
module pic_dev_model
  import pic_host_pkg::*;
(
  // host pins
  input  wire logic       cmd_write,
  input  wire logic [2:0] cmd_opcode,
  input  wire logic [7:0] cmd_data,
  input  wire logic       acknowledge_strobe_n,
  output logic            dev_int,
  output logic [2:0]      ack_level,
  // peripheral requests
  input  wire logic [7:0] request_inputs
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] request_mask         = MASK_RESET;
  logic [7:0] in_service_bits      = '0;
  logic [7:0] edge_seen            = '0;
  logic [7:0] prev_req             = '0;
  logic [7:0] pending_request_bits;
  logic       special_masking_mode = 1'b0;
  logic       level_mode           = 1'b0;
  logic       auto_mode            = 1'b0;
  logic [2:0] lowest               = 3'h7;
  int         pulses               = 0;
  int         win;

  // highest ranked set bit, 8 when empty
  function automatic int top(input logic [7:0] v, input logic [2:0] lo);
    for (int k = 1; k <= 8; k++)
      if (v[3'(lo + k)])
        return int'(3'(lo + k));
    return 8;
  endfunction : top

  function automatic logic [7:0] live_isr();
    return special_masking_mode ? in_service_bits & ~request_mask : in_service_bits;
  endfunction : live_isr

  always_comb
  begin
    int r;
    int s;
    r = 8;
    s = 8;
    pending_request_bits = level_mode ? request_inputs : edge_seen & request_inputs;
    r = top(pending_request_bits & ~request_mask, lowest);
    s = top(live_isr(), lowest);
    win = (r < 8 && (s == 8 || 3'(r - lowest - 1) < 3'(s - lowest - 1))) ? r : 8;
    dev_int = win < 8;
  end

  always @(request_inputs)
  begin
    edge_seen = edge_seen | (request_inputs & ~prev_req);
    prev_req = request_inputs;
  end

  task automatic ns_clear();
    int t;
    t = top(live_isr(), lowest);
    if (t < 8)
      in_service_bits[t] = 1'b0;
  endtask : ns_clear

  ////////////////////////////////////////
  always @(posedge cmd_write)
    case (cmd_opcode)
      OP_INIT:
      begin
        level_mode = cmd_data[LEVEL_BIT];
        auto_mode = cmd_data[AUTO_BIT];
        in_service_bits = '0;
        edge_seen = '0;
        special_masking_mode = 1'b0;
        lowest = 3'h7;
      end
      OP_NS_EOS:     ns_clear();
      OP_SP_EOS:     in_service_bits[cmd_data[2:0]] = 1'b0;
      OP_ROT_SP_EOS:
      begin
        in_service_bits[cmd_data[2:0]] = 1'b0;
        lowest = cmd_data[2:0];
      end
      OP_SET_PRIO:   lowest = cmd_data[2:0];
      OP_SMM_SET:    special_masking_mode = 1'b1;
      OP_SMM_CLR:    special_masking_mode = 1'b0;
      default:       request_mask = cmd_data;
    endcase

  // only an acknowledge sets a service bit
  always @(negedge acknowledge_strobe_n)
  begin
    pulses = pulses + 1;
    if (pulses == 1)
    begin
      ack_level = (win < 8) ? win[2:0] : DEFAULT_LEVEL;
      if (win < 8)
      begin
        in_service_bits[win] = 1'b1;
        edge_seen[win] = 1'b0;
      end
    end
  end

  always @(posedge acknowledge_strobe_n)
    if (pulses == ACK_PULSES)
    begin
      pulses = 0;
      if (auto_mode)
        ns_clear();
    end
endmodule : pic_dev_model

// file: tb/pic_host_tb.sv
/*
  bench for pic_host: apb master, request lines, device model.
  assumes status bit0 busy, bit1 dev_int, bit2 special masking.
*/
module pic_host_tb
  import pic_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic        pready, pslverr, dev_int, cmd_write, strobe_n, err;
  logic [2:0]  ack_level, cmd_opcode;
  logic [7:0]  cmd_data, req = '0;
  int          bad_count = 0, tests_run = 0;

  pic_host #(.STROBE_CYCLES(2)) DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dev_int(dev_int), .ack_level(ack_level), .cmd_write(cmd_write),
    .cmd_opcode(cmd_opcode), .cmd_data(cmd_data), .acknowledge_strobe_n(strobe_n));
  pic_dev_model dev (.cmd_write(cmd_write), .cmd_opcode(cmd_opcode), .cmd_data(cmd_data),
    .acknowledge_strobe_n(strobe_n), .dev_int(dev_int), .ack_level(ack_level),
    .request_inputs(req));

  initial
    forever #2.5 clk = ~clk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && n++ < 100);
    if (pready !== 1'b1)
      bad_count++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // write, then wait for the sequencer to go idle
  task automatic put(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    apb(1'b1, a, d);
    do apb(1'b0, OFF_STATUS, '0); while (q[0] !== 1'b0 && n++ < 50);
    if (q[0] !== 1'b0)
      bad_count++;
  endtask : put

  task automatic cmd(input logic [3:0] c, input logic [7:0] l);
    put(OFF_CMD, {20'h0, c, l});
  endtask : cmd

  task automatic irq(input logic e);
    repeat (4) @(posedge clk);
    apb(1'b0, OFF_STATUS, '0);
    check("dev_int", 32'(q[1]), 32'(e));
  endtask : irq

  task automatic ack(input logic [2:0] l);
    cmd(CMD_ACK, 8'h00);
    apb(1'b0, OFF_VECTOR, '0);
    check("vector", q, {28'h0, 1'b1, l});
  endtask : ack

  ////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, OFF_MASK, '0);
    check("mask reset", q, {24'h0, MASK_RESET});
    apb(1'b0, 12'h010, '0);
    check("unmapped", 32'(err), 32'h1);
    put(OFF_MASK, 32'h5a);
    apb(1'b0, OFF_MASK, '0);
    check("mask rw", q, 32'h5a);
  endtask : t_regs

  task automatic t_level();
    cmd(CMD_INIT, 8'h10);
    put(OFF_MASK, 32'hff);
    req <= 8'h08;
    irq(1'b0);
    put(OFF_MASK, 32'h00);
    irq(1'b1);
    put(OFF_MASK, 32'hff);
    req <= 8'h00;
    put(OFF_MASK, 32'h00);
    irq(1'b0);
    req <= 8'h08;
    ack(3'h3);
    irq(1'b0);
    cmd(CMD_NS_EOS, 8'h00);
    irq(1'b1);
    ack(3'h3);
    req <= 8'h24;
    ack(3'h2);
    req <= 8'h20;
    cmd(CMD_NS_EOS, 8'h00);
    irq(1'b0);
    put(OFF_MASK, 32'h08);
    cmd(CMD_SMM_SET, 8'h00);
    irq(1'b1);
    check("smm flag", 32'(q[2]), 32'h1);
    ack(3'h5);
    put(OFF_MASK, 32'h28);
    req <= 8'h60;
    ack(3'h6);
    apb(1'b1, OFF_CMD, {20'h0, CMD_NS_EOS, 8'h00});
    check("ns refused", 32'(err), 32'h1);
    for (int i = 3; i < 7; i++)
      cmd(CMD_SP_EOS, 8'(i));
    cmd(CMD_SMM_CLR, 8'h00);
    put(OFF_MASK, 32'h00);
    req <= 8'h00;
    irq(1'b0);
  endtask : t_level

  task automatic t_rot();
    req <= 8'h08;
    ack(3'h3);
    req <= 8'h14;
    cmd(CMD_ROT_SP_EOS, 8'h03);
    ack(3'h4);
    irq(1'b0);
    cmd(CMD_SET_PRIO, 8'h03);
    check("prio flag", 32'(q[3]), 32'h1);
    apb(1'b1, OFF_CMD, {20'h0, CMD_NS_EOS, 8'h00});
    check("ns refused", 32'(err), 32'h1);
    cmd(CMD_SP_EOS, 8'h04);
    cmd(CMD_INIT, 8'h30);
    check("init mode", 32'(q[5:4]), 32'h3);
    ack(3'h2);
    irq(1'b1);
    req <= 8'h00;
  endtask : t_rot

  task automatic t_edge();
    req <= 8'h02;
    cmd(CMD_INIT, 8'h00);
    irq(1'b0);
    req <= 8'h00;
    ack(3'h7);
    req <= 8'h02;
    irq(1'b1);
    ack(3'h1);
    cmd(CMD_SP_EOS, 8'h01);
    irq(1'b0);
    req <= 8'h00;
    @(posedge clk);
    req <= 8'h02;
    irq(1'b1);
  endtask : t_edge

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  initial
  begin
    #200us;
    bad_count++;
    end_sim();
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_level();
    t_rot();
    t_edge();
    end_sim();
  end
endmodule : pic_host_tb
